// ==== core/tsr_regs.v ====
`timescale 1ns/100ps
`include "tsr_defines.vh"

// Thermistor control and state-of-charge breakpoint bytes, reached over the
// two-wire serial bus as a target. A write frame carries the register
// pointer and then data bytes; a read frame returns bytes from the pointer.
// The pointer advances after every data byte in either direction.
module tsr_regs #(
  // Seven-bit bus address; the value is arbitrary.
  parameter [6:0] DEVICE_ADDR = 7'h2a
) (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Serial bus pins; data is open drain.
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Factory trim caught while reset is held.
  input wire trim_resistance_select,
  input wire [3:0] trim_beta_code,
  // Measured battery temperature in degrees Celsius.
  input wire signed [7:0] battery_temp_c,
  // Thermistor settings and charge decision.
  output wire [12:0] beta_value,
  output wire thermistor_high_ohm,
  output wire signed [7:0] cold_stop_c,
  output wire signed [7:0] hot_stop_c,
  output wire charge_stop,
  output wire [6:0] charge_current_pct,
  // Breakpoint voltages in millivolts, lowest charge first.
  output reg [12:0] soc_0_mv,
  output reg [12:0] soc_5_mv,
  output reg [12:0] soc_11_mv,
  output reg [12:0] soc_19_mv,
  output reg [12:0] soc_28_mv
);

  // Bus states. Each acknowledge state lasts one serial clock period, except that a
  // not-acknowledge ends ST_RDATA_ACK at the clock rise; the byte states count
  // eight clock rises before they hand over.
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_PTR_ACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WDATA_ACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RDATA_ACK = 4'h8;

  // The six register bytes.
  reg [7:0] thermistor_charge_control;
  reg [7:0] soc_zero_voltage_point;
  reg [7:0] soc_five_voltage_point;
  reg [7:0] soc_eleven_voltage_point;
  reg [7:0] soc_nineteen_voltage_point;
  reg [7:0] soc_twentyeight_voltage_point;

  // Bus engine state.
  reg [3:0] state; // Current bus state.
  reg [3:0] bit_cnt; // Bits moved in the current byte.
  reg [7:0] shift; // Receive or transmit shifter.
  reg [7:0] pointer; // Register pointer.
  reg read_frame; // Direction bit of the address byte.
  reg scl_q; // Previous clock level, for edges.
  reg sda_q; // Previous data level, for start and stop.
  reg wr_stb; // One-cycle write request to the bank.
  reg [7:0] wr_addr; // Target of the write request.
  reg [7:0] wr_data; // Data of the write request.

  // Bus events. Pins are taken as synchronous, so a one-cycle history is
  // enough to find edges.
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_seen = scl && scl_q && sda_q && !sda_in;
  assign stop_seen = scl && scl_q && !sda_q && sda_in;

  // Breakpoint code to millivolts: base plus eight per step.
  function [12:0] code_to_mv;
    input [7:0] code;
    begin
      code_to_mv = `TSR_MV_BASE + ({5'h00, code} * `TSR_MV_STEP);
    end
  endfunction

  // Read mux; unmapped pointers read as zero rather than stale data.
  function [7:0] read_byte;
    input [7:0] addr;
    begin
      case (addr)
        `TSR_OFS_THERM: read_byte = thermistor_charge_control;
        `TSR_OFS_SOC0: read_byte = soc_zero_voltage_point;
        `TSR_OFS_SOC5: read_byte = soc_five_voltage_point;
        `TSR_OFS_SOC11: read_byte = soc_eleven_voltage_point;
        `TSR_OFS_SOC19: read_byte = soc_nineteen_voltage_point;
        `TSR_OFS_SOC28: read_byte = soc_twentyeight_voltage_point;
        default: read_byte = `TSR_READ_NONE;
      endcase
    end
  endfunction

  // Byte that a read sends next. A bit cannot be picked straight out of a
  // function call, so the byte gets a name of its own.
  wire [7:0] read_next;
  assign read_next = read_byte(pointer);

  // Pin history for edge detection. Both start at the idle level of the
  // pins, so no false edge and no false start follows a reset.
  always @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Bus engine. Data is sampled on clock rise and changed on clock fall;
  // the acknowledge is driven across the ninth clock. Start and stop take
  // priority over any bit activity in the same cycle.
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      pointer <= 8'h00;
      read_frame <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      sda_out <= 1'b0;
      wr_stb <= 1'b0;
      if (start_seen) begin
        // A repeated start keeps the pointer for a read-after-write.
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        // A stop ends the frame; a half-received byte is dropped.
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            // The line stays released until a start.
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise && bit_cnt != `TSR_BITS_PER_BYTE) begin
              shift <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `TSR_BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                // Ignore frames for other targets until the next start.
                if (shift[7:1] == DEVICE_ADDR) begin
                  read_frame <= shift[0];
                  sda_oe <= 1'b1;
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_PTR) begin
                pointer <= shift;
                sda_oe <= 1'b1;
                state <= ST_PTR_ACK;
              end else begin
                // Each data byte lands at the pointer, then it advances.
                wr_stb <= 1'b1;
                wr_addr <= pointer;
                wr_data <= shift;
                pointer <= pointer + 8'h01;
                sda_oe <= 1'b1;
                state <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (read_frame) begin
                // The first bit goes out as the acknowledge clock falls.
                shift <= read_next;
                sda_oe <= !read_next[7];
                state <= ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              // Let go; further data bytes may follow.
              sda_oe <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              // The controller takes the bit on this rise; just count it.
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `TSR_BITS_PER_BYTE) begin
                // Let go of the line for the controller's acknowledge.
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                pointer <= pointer + 8'h01;
                state <= ST_RDATA_ACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_oe <= !shift[6];
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise && sda_in) begin
              // Not acknowledged: the controller wants no more bytes.
              state <= ST_IDLE;
            end else if (scl_fall) begin
              // Acknowledged: the next byte comes from the advanced pointer.
              shift <= read_next;
              sda_oe <= !read_next[7];
              state <= ST_RDATA;
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register bank. The trim fields have no fixed reset value: they follow
  // the factory trim inputs while reset is held. Software may overwrite
  // the beta code, though the trimmed value is then lost until reset.
  always @(posedge clk) begin
    if (reset) begin
      thermistor_charge_control <= {`TSR_RST_COOL_CUR, `TSR_RST_COLD_SEL,
        `TSR_RST_HOT_SEL, trim_resistance_select, trim_beta_code};
      soc_zero_voltage_point <= `TSR_RST_SOC0;
      soc_five_voltage_point <= `TSR_RST_SOC5;
      soc_eleven_voltage_point <= `TSR_RST_SOC11;
      soc_nineteen_voltage_point <= `TSR_RST_SOC19;
      soc_twentyeight_voltage_point <= `TSR_RST_SOC28;
    end else if (wr_stb) begin
      // Writes to unmapped pointers are acknowledged and dropped.
      case (wr_addr)
        `TSR_OFS_THERM: thermistor_charge_control <= wr_data;
        `TSR_OFS_SOC0: soc_zero_voltage_point <= wr_data;
        `TSR_OFS_SOC5: soc_five_voltage_point <= wr_data;
        `TSR_OFS_SOC11: soc_eleven_voltage_point <= wr_data;
        `TSR_OFS_SOC19: soc_nineteen_voltage_point <= wr_data;
        `TSR_OFS_SOC28: soc_twentyeight_voltage_point <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Breakpoint voltages for the gauge, in ascending charge order.
  // The extra register stage keeps the multiply out of the gauge's path.
  always @(posedge clk) begin
    if (reset) begin
      soc_0_mv <= 13'h0000;
      soc_5_mv <= 13'h0000;
      soc_11_mv <= 13'h0000;
      soc_19_mv <= 13'h0000;
      soc_28_mv <= 13'h0000;
    end else begin
      soc_0_mv <= code_to_mv(soc_zero_voltage_point);
      soc_5_mv <= code_to_mv(soc_five_voltage_point);
      soc_11_mv <= code_to_mv(soc_eleven_voltage_point);
      soc_19_mv <= code_to_mv(soc_nineteen_voltage_point);
      soc_28_mv <= code_to_mv(soc_twentyeight_voltage_point);
    end
  end

  // Thermistor decode and charge decision.
  // It reads the live control byte, so a write takes effect one clock after the byte is written.
  tsr_thermal u_thermal (
    .clk(clk),
    .reset(reset),
    .control(thermistor_charge_control),
    .battery_temp_c(battery_temp_c),
    .beta_value(beta_value),
    .thermistor_high_ohm(thermistor_high_ohm),
    .cold_stop_c(cold_stop_c),
    .hot_stop_c(hot_stop_c),
    .charge_stop(charge_stop),
    .charge_current_pct(charge_current_pct)
  );

endmodule // tsr_regs

// ==== core/tsr_defines.vh ====
// Notes on behaviour
// - Bit 7 picks cool-band current: half or tenth.
// - Bit 6 picks cold stop: 0 or 10 C.
// - Bit 5 picks hot stop: 45 or 60 C.
// - Bit 4 picks thermistor: 10k or 100k/47k.
// - Bits 3:0 select one of sixteen beta values.
// - Trim bits load from factory; others fixed.
// - Breakpoint volts equal 2.5 plus code times 0.008.
// - Five breakpoints: 0,5,11,19,28 percent, ascending.
// - Lower breakpoints reset to 0x7c, 0x91, 0x94.
// - Upper breakpoints reset to 3.724 and 3.764 V.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// Register offsets on the serial bus.
`define TSR_OFS_THERM 8'h0c
`define TSR_OFS_SOC0 8'h0d
`define TSR_OFS_SOC5 8'h0e
`define TSR_OFS_SOC11 8'h0f
`define TSR_OFS_SOC19 8'h10
`define TSR_OFS_SOC28 8'h11

// Field positions in the thermistor control byte.
`define TSR_BIT_COOL_CUR 7
`define TSR_BIT_COLD_SEL 6
`define TSR_BIT_HOT_SEL 5
`define TSR_BIT_RES_SEL 4
`define TSR_BETA_MSB 3
`define TSR_BETA_LSB 0

// Reset values of the fixed fields and the breakpoints.
`define TSR_RST_COOL_CUR 1'b0
`define TSR_RST_COLD_SEL 1'b0
`define TSR_RST_HOT_SEL 1'b1
`define TSR_RST_SOC0 8'h7c
`define TSR_RST_SOC5 8'h91
`define TSR_RST_SOC11 8'h94
`define TSR_RST_SOC19 8'h99
`define TSR_RST_SOC28 8'h9e

// Breakpoint scaling in millivolts.
`define TSR_MV_BASE 13'h09c4
`define TSR_MV_STEP 13'h0008

// Temperature thresholds in degrees Celsius.
`define TSR_COLD_LO 8'sh00
`define TSR_COLD_HI 8'sh0a
`define TSR_HOT_LO 8'sh2d
`define TSR_HOT_HI 8'sh3c
`define TSR_COOL_TOP 8'sh0a

// Charge current as a percentage of the programmed value.
`define TSR_PCT_FULL 7'h64
`define TSR_PCT_HALF 7'h32
`define TSR_PCT_TENTH 7'h0a
`define TSR_PCT_NONE 7'h00

// Serial bus framing.
`define TSR_BITS_PER_BYTE 4'h8
`define TSR_READ_NONE 8'h00

`endif

// ==== core/tsr_thermal.v ====
`timescale 1ns/100ps
`include "tsr_defines.vh"

// Turns the thermistor control byte into the values the charger uses and
// decides, from the measured battery temperature, whether to charge and how
// hard.
module tsr_thermal (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Control byte and measured temperature.
  input wire [7:0] control,
  input wire signed [7:0] battery_temp_c,
  // Decoded settings.
  output reg [12:0] beta_value,
  output reg thermistor_high_ohm,
  output reg signed [7:0] cold_stop_c,
  output reg signed [7:0] hot_stop_c,
  // Charge decision.
  output reg charge_stop,
  output reg [6:0] charge_current_pct
);

  // Beta value for each code, rising monotonically across the table.
  function [12:0] beta_lookup;
    input [3:0] code;
    begin
      case (code)
        4'h0: beta_lookup = 13'h092e;
        4'h1: beta_lookup = 13'h0a28;
        4'h2: beta_lookup = 13'h0abe;
        4'h3: beta_lookup = 13'h0bb8;
        4'h4: beta_lookup = 13'h0c4e;
        4'h5: beta_lookup = 13'h0d16;
        4'h6: beta_lookup = 13'h0dac;
        4'h7: beta_lookup = 13'h0e10;
        4'h8: beta_lookup = 13'h0ed8;
        4'h9: beta_lookup = 13'h0fa0;
        4'ha: beta_lookup = 13'h1068;
        4'hb: beta_lookup = 13'h1130;
        4'hc: beta_lookup = 13'h11f8;
        4'hd: beta_lookup = 13'h12c0;
        4'he: beta_lookup = 13'h1388;
        default: beta_lookup = 13'h1450;
      endcase
    end
  endfunction

  // Thresholds chosen by the control byte, settled combinationally.
  wire signed [7:0] cold_sel;
  wire signed [7:0] hot_sel;
  assign cold_sel = control[`TSR_BIT_COLD_SEL] ? `TSR_COLD_HI : `TSR_COLD_LO;
  assign hot_sel = control[`TSR_BIT_HOT_SEL] ? `TSR_HOT_HI : `TSR_HOT_LO;

  // Temperature comparisons against the selected thresholds.
  wire too_cold;
  wire too_hot;
  wire in_cool_band;
  assign too_cold = battery_temp_c < cold_sel;
  assign too_hot = battery_temp_c > hot_sel;
  assign in_cool_band = (battery_temp_c >= `TSR_COLD_LO) &&
    (battery_temp_c < `TSR_COOL_TOP);

  // Everything is registered so the charger sees glitch-free settings even
  // while the host is halfway through rewriting the byte.
  always @(posedge clk) begin
    if (reset) begin
      beta_value <= 13'h0000;
      thermistor_high_ohm <= 1'b0;
      cold_stop_c <= `TSR_COLD_LO;
      hot_stop_c <= `TSR_HOT_LO;
      charge_stop <= 1'b1;
      charge_current_pct <= `TSR_PCT_NONE;
    end else begin
      beta_value <= beta_lookup(control[`TSR_BETA_MSB:`TSR_BETA_LSB]);
      thermistor_high_ohm <= control[`TSR_BIT_RES_SEL];
      cold_stop_c <= cold_sel;
      hot_stop_c <= hot_sel;
      charge_stop <= too_cold || too_hot;
      // Stopping wins over the cool-band reduction.
      if (too_cold || too_hot) begin
        charge_current_pct <= `TSR_PCT_NONE;
      end else if (in_cool_band) begin
        charge_current_pct <= control[`TSR_BIT_COOL_CUR] ?
          `TSR_PCT_TENTH : `TSR_PCT_HALF;
      end else begin
        charge_current_pct <= `TSR_PCT_FULL;
      end
    end
  end

endmodule // tsr_thermal

// ==== verif/tsr_regs_asserts.sv ====
`timescale 1ns/100ps
// Watches the pins of the register bank for slips in decode and bus timing.
module tsr_regs_asserts (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Bus pins.
  input wire scl,
  input wire sda_out,
  input wire sda_oe,
  // Temperature and decoded settings.
  input wire signed [7:0] battery_temp_c,
  input wire [12:0] beta_value,
  input wire signed [7:0] cold_stop_c,
  input wire signed [7:0] hot_stop_c,
  input wire charge_stop,
  input wire [6:0] charge_current_pct,
  // Breakpoint voltages.
  input wire [12:0] soc_0_mv,
  input wire [12:0] soc_5_mv,
  input wire [12:0] soc_11_mv,
  input wire [12:0] soc_19_mv,
  input wire [12:0] soc_28_mv
);
  // One clock domain, so one default clock and disable.
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  drive_low_a: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  // The pin may only move at an edge that has just seen the clock fall.
  ack_timing_a: assert property ($changed(sda_oe) |->
    $past(scl, 2) && !$past(scl))
    else $error("data pin moved outside a clock fall");
  cold_set_a: assert property (
    cold_stop_c == 8'sh00 || cold_stop_c == 8'sh0a)
    else $error("cold threshold not 0 or 10");
  hot_set_a: assert property (
    hot_stop_c == 8'sh2d || hot_stop_c == 8'sh3c)
    else $error("hot threshold not 45 or 60");
  // Judged only while temperature and thresholds hold still.
  stop_rule_a: assert property (!$past(reset) && !$past(reset, 2) &&
    $stable(battery_temp_c) && $stable(cold_stop_c) &&
    $stable(hot_stop_c) |-> charge_stop ==
    (battery_temp_c < cold_stop_c || battery_temp_c > hot_stop_c))
    else $error("charge stop disagrees with thresholds");
  pct_rule_a: assert property (!$past(reset) && !$past(reset, 2) &&
    $stable(battery_temp_c) |->
    (charge_stop && charge_current_pct == 7'h00) ||
    (!charge_stop && battery_temp_c >= 0 && battery_temp_c < 10 &&
    (charge_current_pct == 7'h0a || charge_current_pct == 7'h32)) ||
    (!charge_stop && !(battery_temp_c >= 0 && battery_temp_c < 10) &&
    charge_current_pct == 7'h64))
    else $error("charge current percentage wrong");
  soc_scale_a: assert property (!$past(reset) && !$past(reset, 2) |->
    soc_0_mv >= 13'h09c4 && soc_5_mv >= 13'h09c4 &&
    soc_11_mv >= 13'h09c4 && soc_19_mv >= 13'h09c4 &&
    soc_28_mv >= 13'h09c4 && soc_0_mv[2:0] == 3'h4 &&
    soc_5_mv[2:0] == 3'h4 && soc_11_mv[2:0] == 3'h4 &&
    soc_19_mv[2:0] == 3'h4 && soc_28_mv[2:0] == 3'h4)
    else $error("breakpoint off the voltage grid");
  beta_table_a: assert property (!$past(reset) && !$past(reset, 2) |->
    beta_value inside {2350, 2600, 2750, 3000, 3150, 3350, 3500, 3600,
    3800, 4000, 4200, 4400, 4600, 4800, 5000, 5200})
    else $error("beta value not in table");
endmodule // tsr_regs_asserts

bind tsr_regs tsr_regs_asserts chk (.clk(clk), .reset(reset), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .battery_temp_c(battery_temp_c),
  .beta_value(beta_value), .cold_stop_c(cold_stop_c),
  .hot_stop_c(hot_stop_c), .charge_stop(charge_stop),
  .charge_current_pct(charge_current_pct), .soc_0_mv(soc_0_mv),
  .soc_5_mv(soc_5_mv), .soc_11_mv(soc_11_mv), .soc_19_mv(soc_19_mv),
  .soc_28_mv(soc_28_mv));

// ==== verif/tsr_regs_test.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch at %0t: %h vs %h", $time, got, exp); end end

// Acts as bus controller for the register bank and checks it against a model.
module tsr_regs_test;
  localparam [6:0] ADDR = 7'h2a; // Bus address; the value is arbitrary.
  reg clk, reset, scl, sda_m, trim_res, ack;
  reg [3:0] trim_beta;
  reg signed [7:0] temp;
  reg [7:0] got;
  reg [7:0] wbuf [0:5]; // Bytes for the next write frame.
  wire sda_out, sda_oe, high_ohm, charge_stop;
  wire [12:0] beta_value, mv0, mv5, mv11, mv19, mv28;
  wire signed [7:0] cold_c, hot_c;
  wire [6:0] pct;
  wire [64:0] mvs = {mv28, mv19, mv11, mv5, mv0};
  wire sda_in = sda_m & ~sda_oe; // Pull-up wins unless someone pulls low.
  integer n_errors = 0, tests_run = 0, i, j, k, t, stp, e;
  integer mdl [0:5]; // Model of the bytes at offsets 0x0c to 0x11.
  integer beta_tab [0:15] = '{2350, 2600, 2750, 3000, 3150, 3350, 3500,
    3600, 3800, 4000, 4200, 4400, 4600, 4800, 5000, 5200};

  tsr_regs #(.DEVICE_ADDR(ADDR)) dut (.clk(clk), .reset(reset), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .trim_resistance_select(trim_res), .trim_beta_code(trim_beta),
    .battery_temp_c(temp), .beta_value(beta_value),
    .thermistor_high_ohm(high_ohm), .cold_stop_c(cold_c), .hot_stop_c(hot_c),
    .charge_stop(charge_stop), .charge_current_pct(pct), .soc_0_mv(mv0),
    .soc_5_mv(mv5), .soc_11_mv(mv11), .soc_19_mv(mv19), .soc_28_mv(mv28));

  // Free-running 100 MHz clock.
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // All stimulus moves at falling edges, clear of the sampling edge.
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Serial clock low and high each stay several cycles, as the port needs.
  task put_bit(input reg v);
    begin sda_m = v; tick(2); scl = 1; tick(3); scl = 0; tick(1); end
  endtask
  task get_bit(output reg v);
    begin sda_m = 1; tick(2); scl = 1; tick(2); v = sda_in; tick(1);
      scl = 0; tick(1); end
  endtask
  // Sends a byte and expects the target to acknowledge it.
  task send(input [7:0] d);
    begin
      for (k = 7; k >= 0; k--) put_bit(d[k]);
      get_bit(ack);
      `CHK(ack, 1'b0)
    end
  endtask
  task start;
    begin sda_m = 1; tick(2); scl = 1; tick(3); sda_m = 0; tick(3);
      scl = 0; tick(2); end
  endtask
  task stop;
    begin sda_m = 0; tick(2); scl = 1; tick(3); sda_m = 1; tick(3); end
  endtask
  // Writes n bytes from wbuf at ptr; the model follows mapped offsets only.
  task wr(input [7:0] ptr, input integer n);
    begin
      start; send({ADDR, 1'b0}); send(ptr);
      for (i = 0; i < n; i++) begin
        send(wbuf[i]);
        if (ptr + i >= 12 && ptr + i <= 17) mdl[ptr + i - 12] = wbuf[i];
      end
      stop; tick(4);
    end
  endtask
  // Reads n bytes from ptr; unmapped offsets must read as zero.
  task rd(input [7:0] ptr, input integer n);
    begin
      start; send({ADDR, 1'b0}); send(ptr); start; send({ADDR, 1'b1});
      for (i = 0; i < n; i++) begin
        for (k = 7; k >= 0; k--) get_bit(got[k]);
        put_bit(i == n - 1);
        e = (ptr + i >= 12 && ptr + i <= 17) ? mdl[ptr + i - 12] : 0;
        `CHK(got, e)
      end
      stop;
    end
  endtask
  // Compares every decoded output with the model.
  task check_dec;
    begin
      `CHK(beta_value, beta_tab[mdl[0] & 15])
      `CHK(high_ohm, mdl[0][4])
      `CHK(cold_c, mdl[0][6] ? 10 : 0)
      `CHK(hot_c, mdl[0][5] ? 60 : 45)
      for (j = 0; j < 5; j++)
        `CHK(mvs[13*j +: 13], 2500 + 8 * mdl[j + 1])
    end
  endtask
  // Reset with fresh trim; the fixed bits and breakpoints take their codes.
  task do_reset;
    begin
      reset = 1; trim_res = $urandom; trim_beta = $urandom; tick(5);
      reset = 0; tick(3);
      mdl[0] = {3'b001, trim_res, trim_beta};
      mdl[1] = 8'h7c; mdl[2] = 8'h91; mdl[3] = 8'h94;
      mdl[4] = 8'h99; mdl[5] = 8'h9e;
      check_dec; rd(8'h0c, 6);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // A hang is cut off at 50k cycles, well beyond the expected 12k or so.
  initial begin
    #500000;
    n_errors++;
    complete_run;
  end

  initial begin
    scl = 1; sda_m = 1; temp = 25; reset = 1; trim_res = 0; trim_beta = 0;
    t = $urandom(21784);
    do_reset;
    // Every beta code with random upper bits, read back after each write.
    for (t = 0; t < 16; t++) begin
      wbuf[0] = ($urandom & 8'hf0) | t; wr(8'h0c, 1); check_dec;
      rd(8'h0c, 1);
    end
    // All threshold and current combinations across a temperature sweep.
    for (t = 0; t < 8; t++) begin
      wbuf[0] = {t[2:0], mdl[0][4:0]}; wr(8'h0c, 1); check_dec;
      for (i = -2; i <= 62; i++) begin
        temp = i; tick(3);
        stp = i < (mdl[0][6] ? 10 : 0) || i > (mdl[0][5] ? 60 : 45);
        `CHK(charge_stop, stp[0])
        e = stp ? 0 : (i >= 0 && i < 10) ? (mdl[0][7] ? 10 : 50) : 100;
        `CHK(pct, e)
      end
    end
    // Burst of random breakpoints, then a burst read across the bank.
    for (i = 0; i < 5; i++) wbuf[i] = $urandom;
    wr(8'h0d, 5); check_dec; rd(8'h0c, 6);
    // Unmapped offset takes a write silently and reads back as zero.
    wbuf[0] = 8'h5a; wr(8'h12, 1); rd(8'h11, 2);
    // Another bus address must draw no acknowledge.
    start;
    for (k = 7; k >= 0; k--)
      put_bit(k == 0 ? 1'b0 : ADDR[k - 1] ^ (k == 1));
    get_bit(ack); stop;
    `CHK(ack, 1'b1)
    do_reset;
    complete_run;
  end
endmodule // tsr_regs_test
